// [design/timer_cc_pkg.sv]
`default_nettype none

package timer_cc_pkg;

  // register offsets as seen by the port instructions (low range)
  // and as data-space addresses (extended range)
  localparam logic [7:0] OFS_CAPTURE1_LOW = 8'h26;
  localparam logic [7:0] OFS_CAPTURE1_HIGH = 8'h27;
  localparam logic [7:0] OFS_TIMER_FLAGS = 8'h36;
  localparam logic [7:0] OFS_TIMER_IRQ_MASK = 8'h37;
  localparam logic [7:0] OFS_COMPARE1C_LOW = 8'h78;
  localparam logic [7:0] OFS_COMPARE1C_HIGH = 8'h79;
  localparam logic [7:0] OFS_CAPTURE3_LOW = 8'h80;
  localparam logic [7:0] OFS_CAPTURE3_HIGH = 8'h81;
  localparam logic [7:0] OFS_COMPARE3C_LOW = 8'h82;
  localparam logic [7:0] OFS_COMPARE3C_HIGH = 8'h83;
  localparam logic [7:0] OFS_COMPARE3B_LOW = 8'h84;
  localparam logic [7:0] OFS_COMPARE3B_HIGH = 8'h85;
  localparam logic [7:0] OFS_COMPARE3A_LOW = 8'h86;
  localparam logic [7:0] OFS_COMPARE3A_HIGH = 8'h87;

  // address spaces
  localparam logic [7:0] IO_PORT_LIMIT = 8'h40;
  localparam logic [7:0] IO_DATA_BASE = 8'h20;
  localparam logic [7:0] EXT_IO_BASE = 8'h60;

  // field positions in mask and flag registers
  localparam int unsigned BIT_T1_CAPTURE = 5;
  localparam int unsigned BIT_T1_MATCH_A = 4;
  localparam int unsigned BIT_T1_MATCH_B = 3;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

endpackage : timer_cc_pkg

`default_nettype wire

// [design/capture_unit.sv]
`default_nettype none

// holds one 16-bit capture value; latches the counter on a trigger edge
module capture_unit (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic trigger,
  input wire logic edge_rising,
  input wire logic capture_enable,
  input wire logic [15:0] counter_value,
  input wire logic write_en,
  input wire logic [15:0] write_value,
  output logic [15:0] value_q,
  output logic event_q
);

  logic trig_q;
  logic trig_d;
  logic armed_q;
  logic armed_d;
  logic [15:0] value_d;
  logic event_d;

  always_comb begin
    logic edge_seen;
    edge_seen = 1'b0;
    trig_d = trigger;
    armed_d = 1'b1;
    edge_seen = edge_rising ? (trigger & ~trig_q) : (~trigger & trig_q);
    // first cycle after reset only loads the pin history: no false edge
    event_d = edge_seen & capture_enable & armed_q;
    value_d = value_q;
    if (write_en) begin
      value_d = write_value;
    end
    if (event_d) begin
      value_d = counter_value;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_q <= 1'b0;
      armed_q <= 1'b0;
      value_q <= timer_cc_pkg::RST_WORD;
      event_q <= 1'b0;
    end else begin
      trig_q <= trig_d;
      armed_q <= armed_d;
      value_q <= value_d;
      event_q <= event_d;
    end
  end

endmodule : capture_unit

`default_nettype wire

// [design/match_unit.sv]
`default_nettype none

// one compare unit: pulses on the timer tick where counter equals compare
module match_unit (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic timer_tick,
  input wire logic counter_written,
  input wire logic [15:0] counter_value,
  input wire logic [15:0] compare_value,
  output logic match_q
);

  logic block_q;
  logic block_d;
  logic match_d;

  always_comb begin
    block_d = block_q;
    if (counter_written) begin
      block_d = 1'b1;
    end else if (timer_tick) begin
      block_d = 1'b0;
    end
    // blocked compare is dropped for the tick after a counter write
    match_d = timer_tick & (counter_value == compare_value)
              & ~block_q & ~counter_written;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      block_q <= 1'b0;
      match_q <= 1'b0;
    end else begin
      block_q <= block_d;
      match_q <= match_d;
    end
  end

endmodule : match_unit

`default_nettype wire

// [design/timer_cc_regs.sv]
// Summary of operation
// - Capture pin event copies counter to capture
// - Timer 1 capture source may be comparator
// - Capture value may serve as counter TOP
// - Capture low read latches high byte for later
// - One shared high-byte holding register for all
// - Data-space address is port offset plus 0x20
// - Mask bit 5 enables timer 1 capture interrupt
// - Mask bit 4 enables timer 1 match A
// - Mask bit 3 enables timer 1 match B
// - Capture flag cleared by vector or written one
// - Match flag set after equality, not forced
// - Counter write blocks next compare match
`default_nettype none

module timer_cc_regs (
  input wire logic sys_clk,
  input wire logic rst_n,
  // cpu register port
  input wire logic io_port_access,
  input wire logic [7:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata_q,
  // timer 1 side
  input wire logic [15:0] counter1_value,
  input wire logic timer1_tick,
  input wire logic counter1_written,
  input wire logic [15:0] compare1a_value,
  input wire logic [15:0] compare1b_value,
  input wire logic forced_match_a_strobe,
  input wire logic capture_input_pin1,
  input wire logic comparator_out,
  input wire logic capture1_from_comparator,
  input wire logic capture1_edge_rising,
  input wire logic capture1_is_top,
  // timer 3 side
  input wire logic [15:0] counter3_value,
  input wire logic timer3_tick,
  input wire logic counter3_written,
  input wire logic capture_input_pin3,
  input wire logic capture3_edge_rising,
  input wire logic capture3_is_top,
  // interrupt side
  input wire logic global_irq_enable,
  input wire logic t1_capture_vector_ack,
  input wire logic t1_match_a_vector_ack,
  input wire logic t1_match_b_vector_ack,
  output logic irq_t1_capture_q,
  output logic irq_t1_match_a_q,
  output logic irq_t1_match_b_q,
  // values and events towards the rest of the timers
  output logic [15:0] capture1_value_q,
  output logic [15:0] capture3_value_q,
  output logic capture3_event_q,
  output logic match1c_q,
  output logic match3a_q,
  output logic match3b_q,
  output logic match3c_q
);

  // maps a bus access onto a register offset; valid low if unmapped
  function automatic logic [8:0] decode(input logic port_access,
                                        input logic [7:0] addr);
    logic [8:0] res;
    res = {1'b0, 8'h00};
    if (port_access) begin
      if (addr < timer_cc_pkg::IO_PORT_LIMIT) begin
        res = {1'b1, addr};
      end
    end else if (addr >= timer_cc_pkg::EXT_IO_BASE) begin
      res = {1'b1, addr};
    end else if (addr >= timer_cc_pkg::IO_DATA_BASE) begin
      res = {1'b1, addr - timer_cc_pkg::IO_DATA_BASE};
    end
    return res;
  endfunction : decode

  // register state
  logic [7:0] temp_q;
  logic [7:0] temp_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic cap_flag_q;
  logic cap_flag_d;
  logic match_a_flag_q;
  logic match_a_flag_d;
  logic match_b_flag_q;
  logic match_b_flag_d;
  logic [15:0] compare1c_q;
  logic [15:0] compare1c_d;
  logic [15:0] compare3a_q;
  logic [15:0] compare3a_d;
  logic [15:0] compare3b_q;
  logic [15:0] compare3b_d;
  logic [15:0] compare3c_q;
  logic [15:0] compare3c_d;
  logic [7:0] rdata_d;
  logic irq_cap_d;
  logic irq_a_d;
  logic irq_b_d;

  // bus decode
  logic [8:0] dec;
  logic hit;
  logic [7:0] ofs;
  logic wr_cap1;
  logic wr_cap3;
  logic [15:0] wr_word;

  // event sources
  logic cap1_trigger;
  logic capture1_event_q;
  logic match1a_q;
  logic match1b_q;
  logic top1_reached;

  assign dec = decode(io_port_access, io_addr);
  assign hit = dec[8];
  assign ofs = dec[7:0];
  assign wr_word = {temp_q, io_wdata};
  assign wr_cap1 = io_wr & hit & (ofs == timer_cc_pkg::OFS_CAPTURE1_LOW);
  assign wr_cap3 = io_wr & hit & (ofs == timer_cc_pkg::OFS_CAPTURE3_LOW);
  assign cap1_trigger = capture1_from_comparator ? comparator_out
                        : capture_input_pin1;
  assign top1_reached = capture1_is_top & timer1_tick
                        & (counter1_value == capture1_value_q);

  // in TOP mode the capture value is software owned, so pin events are off
  capture_unit u_capture1 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .trigger(cap1_trigger),
    .edge_rising(capture1_edge_rising),
    .capture_enable(~capture1_is_top),
    .counter_value(counter1_value),
    .write_en(wr_cap1),
    .write_value(wr_word),
    .value_q(capture1_value_q),
    .event_q(capture1_event_q)
  );

  capture_unit u_capture3 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .trigger(capture_input_pin3),
    .edge_rising(capture3_edge_rising),
    .capture_enable(~capture3_is_top),
    .counter_value(counter3_value),
    .write_en(wr_cap3),
    .write_value(wr_word),
    .value_q(capture3_value_q),
    .event_q(capture3_event_q)
  );

  // forced strobes never reach the match units, so never set a flag
  match_unit u_match1a (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .timer_tick(timer1_tick),
    .counter_written(counter1_written),
    .counter_value(counter1_value),
    .compare_value(compare1a_value),
    .match_q(match1a_q)
  );

  match_unit u_match1b (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .timer_tick(timer1_tick),
    .counter_written(counter1_written),
    .counter_value(counter1_value),
    .compare_value(compare1b_value),
    .match_q(match1b_q)
  );

  match_unit u_match1c (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .timer_tick(timer1_tick),
    .counter_written(counter1_written),
    .counter_value(counter1_value),
    .compare_value(compare1c_q),
    .match_q(match1c_q)
  );

  match_unit u_match3a (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .timer_tick(timer3_tick),
    .counter_written(counter3_written),
    .counter_value(counter3_value),
    .compare_value(compare3a_q),
    .match_q(match3a_q)
  );

  match_unit u_match3b (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .timer_tick(timer3_tick),
    .counter_written(counter3_written),
    .counter_value(counter3_value),
    .compare_value(compare3b_q),
    .match_q(match3b_q)
  );

  match_unit u_match3c (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .timer_tick(timer3_tick),
    .counter_written(counter3_written),
    .counter_value(counter3_value),
    .compare_value(compare3c_q),
    .match_q(match3c_q)
  );

  // register writes, reads and the shared high-byte latch
  always_comb begin
    logic [7:0] flags;
    flags = 8'h00;
    flags[timer_cc_pkg::BIT_T1_CAPTURE] = cap_flag_q;
    flags[timer_cc_pkg::BIT_T1_MATCH_A] = match_a_flag_q;
    flags[timer_cc_pkg::BIT_T1_MATCH_B] = match_b_flag_q;
    temp_d = temp_q;
    mask_d = mask_q;
    compare1c_d = compare1c_q;
    compare3a_d = compare3a_q;
    compare3b_d = compare3b_q;
    compare3c_d = compare3c_q;
    rdata_d = 8'h00;
    if (io_wr && hit) begin
      case (ofs)
        timer_cc_pkg::OFS_TIMER_IRQ_MASK: mask_d = io_wdata;
        timer_cc_pkg::OFS_COMPARE1C_LOW: compare1c_d = wr_word;
        timer_cc_pkg::OFS_COMPARE3A_LOW: compare3a_d = wr_word;
        timer_cc_pkg::OFS_COMPARE3B_LOW: compare3b_d = wr_word;
        timer_cc_pkg::OFS_COMPARE3C_LOW: compare3c_d = wr_word;
        timer_cc_pkg::OFS_CAPTURE1_HIGH,
        timer_cc_pkg::OFS_CAPTURE3_HIGH,
        timer_cc_pkg::OFS_COMPARE1C_HIGH,
        timer_cc_pkg::OFS_COMPARE3A_HIGH,
        timer_cc_pkg::OFS_COMPARE3B_HIGH,
        timer_cc_pkg::OFS_COMPARE3C_HIGH: temp_d = io_wdata;
        default: ;
      endcase
    end else if (io_rd && hit) begin
      case (ofs)
        timer_cc_pkg::OFS_TIMER_IRQ_MASK: rdata_d = mask_q;
        timer_cc_pkg::OFS_TIMER_FLAGS: rdata_d = flags;
        timer_cc_pkg::OFS_CAPTURE1_LOW: begin
          rdata_d = capture1_value_q[7:0];
          temp_d = capture1_value_q[15:8];
        end
        timer_cc_pkg::OFS_CAPTURE3_LOW: begin
          rdata_d = capture3_value_q[7:0];
          temp_d = capture3_value_q[15:8];
        end
        timer_cc_pkg::OFS_COMPARE1C_LOW: rdata_d = compare1c_q[7:0];
        timer_cc_pkg::OFS_COMPARE3A_LOW: rdata_d = compare3a_q[7:0];
        timer_cc_pkg::OFS_COMPARE3B_LOW: rdata_d = compare3b_q[7:0];
        timer_cc_pkg::OFS_COMPARE3C_LOW: rdata_d = compare3c_q[7:0];
        timer_cc_pkg::OFS_CAPTURE1_HIGH,
        timer_cc_pkg::OFS_CAPTURE3_HIGH: rdata_d = temp_q;
        timer_cc_pkg::OFS_COMPARE1C_HIGH: rdata_d = compare1c_q[15:8];
        timer_cc_pkg::OFS_COMPARE3A_HIGH: rdata_d = compare3a_q[15:8];
        timer_cc_pkg::OFS_COMPARE3B_HIGH: rdata_d = compare3b_q[15:8];
        timer_cc_pkg::OFS_COMPARE3C_HIGH: rdata_d = compare3c_q[15:8];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // timer 1 flags: clear by one written or vector taken, set wins
  always_comb begin
    logic wr_flags;
    wr_flags = io_wr & hit & (ofs == timer_cc_pkg::OFS_TIMER_FLAGS);
    cap_flag_d = cap_flag_q;
    match_a_flag_d = match_a_flag_q;
    match_b_flag_d = match_b_flag_q;
    if (t1_capture_vector_ack
        || (wr_flags && io_wdata[timer_cc_pkg::BIT_T1_CAPTURE])) begin
      cap_flag_d = 1'b0;
    end
    if (t1_match_a_vector_ack
        || (wr_flags && io_wdata[timer_cc_pkg::BIT_T1_MATCH_A])) begin
      match_a_flag_d = 1'b0;
    end
    if (t1_match_b_vector_ack
        || (wr_flags && io_wdata[timer_cc_pkg::BIT_T1_MATCH_B])) begin
      match_b_flag_d = 1'b0;
    end
    if (capture1_event_q || top1_reached) begin
      cap_flag_d = 1'b1;
    end
    if (match1a_q) begin
      match_a_flag_d = 1'b1;
    end
    if (match1b_q) begin
      match_b_flag_d = 1'b1;
    end
    irq_cap_d = mask_q[timer_cc_pkg::BIT_T1_CAPTURE] & cap_flag_q
                & global_irq_enable;
    irq_a_d = mask_q[timer_cc_pkg::BIT_T1_MATCH_A] & match_a_flag_q
              & global_irq_enable;
    irq_b_d = mask_q[timer_cc_pkg::BIT_T1_MATCH_B] & match_b_flag_q
              & global_irq_enable;
  end

  // the forced strobe is accepted and deliberately has no effect on flags
  logic unused_forced;
  assign unused_forced = forced_match_a_strobe;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_q <= timer_cc_pkg::RST_BYTE;
      mask_q <= timer_cc_pkg::RST_BYTE;
      cap_flag_q <= 1'b0;
      match_a_flag_q <= 1'b0;
      match_b_flag_q <= 1'b0;
      compare1c_q <= timer_cc_pkg::RST_WORD;
      compare3a_q <= timer_cc_pkg::RST_WORD;
      compare3b_q <= timer_cc_pkg::RST_WORD;
      compare3c_q <= timer_cc_pkg::RST_WORD;
      io_rdata_q <= timer_cc_pkg::RST_BYTE;
      irq_t1_capture_q <= 1'b0;
      irq_t1_match_a_q <= 1'b0;
      irq_t1_match_b_q <= 1'b0;
    end else begin
      temp_q <= temp_d;
      mask_q <= mask_d;
      cap_flag_q <= cap_flag_d;
      match_a_flag_q <= match_a_flag_d;
      match_b_flag_q <= match_b_flag_d;
      compare1c_q <= compare1c_d;
      compare3a_q <= compare3a_d;
      compare3b_q <= compare3b_d;
      compare3c_q <= compare3c_d;
      io_rdata_q <= rdata_d;
      irq_t1_capture_q <= irq_cap_d;
      irq_t1_match_a_q <= irq_a_d;
      irq_t1_match_b_q <= irq_b_d;
    end
  end

endmodule : timer_cc_regs

`default_nettype wire

// [sim/timer_cc_props.sv]
`default_nettype none

module timer_cc_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic io_port_access,
  input wire logic [7:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_rdata_q,
  input wire logic [15:0] counter3_value,
  input wire logic timer3_tick,
  input wire logic counter3_written,
  input wire logic global_irq_enable,
  input wire logic irq_t1_capture_q,
  input wire logic irq_t1_match_a_q,
  input wire logic irq_t1_match_b_q,
  input wire logic [15:0] capture3_value_q,
  input wire logic capture3_event_q,
  input wire logic match3a_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence lo_rd;
    io_rd && !io_wr && !io_port_access && io_addr == 8'h80;
  endsequence
  sequence hi_rd;
    io_rd && !io_wr && !io_port_access && io_addr == 8'h81;
  endsequence

  chk_port_range: assert property (
    io_rd && !io_wr && io_port_access && io_addr >= 8'h40
    |=> io_rdata_q == 8'h00) else $error("port read out of range");
  chk_data_low: assert property (
    io_rd && !io_wr && !io_port_access && io_addr < 8'h20
    |=> io_rdata_q == 8'h00) else $error("data read below range");
  chk_cap_value: assert property (
    capture3_event_q |-> capture3_value_q == $past(counter3_value))
    else $error("capture value not counter");
  chk_cap_hold: assert property (
    !capture3_event_q && !$past(io_wr) |-> $stable(capture3_value_q))
    else $error("capture changed without event");
  chk_irq_gated: assert property (
    !global_irq_enable |=> !irq_t1_capture_q && !irq_t1_match_a_q
    && !irq_t1_match_b_q) else $error("irq without global enable");
  chk_match_blocked: assert property (
    timer3_tick && counter3_written |=> !match3a_q)
    else $error("match after counter write");
  chk_match_tick: assert property (
    !timer3_tick |=> !match3a_q) else $error("match without tick");
  chk_low_read: assert property (
    lo_rd |=> io_rdata_q == 8'($past(capture3_value_q)))
    else $error("capture low read wrong");
  chk_temp_pair: assert property (
    lo_rd ##1 hi_rd |=> io_rdata_q == 8'($past(capture3_value_q, 2) >> 8))
    else $error("capture high not latched");
endmodule : timer_cc_props

bind timer_cc_regs timer_cc_props chk_u (.sys_clk, .rst_n, .io_port_access,
  .io_addr, .io_rd, .io_wr, .io_rdata_q, .counter3_value, .timer3_tick,
  .counter3_written, .global_irq_enable, .irq_t1_capture_q,
  .irq_t1_match_a_q, .irq_t1_match_b_q, .capture3_value_q,
  .capture3_event_q, .match3a_q);

`default_nettype wire

// [sim/cpu_io_model.sv]
`default_nettype none

// cpu side of the register port; 16-bit writes high first, reads low first
module cpu_io_model (
  input wire logic sys_clk,
  input wire logic [7:0] io_rdata_q,
  output logic io_port_access,
  output logic [7:0] io_addr,
  output logic io_rd,
  output logic io_wr,
  output logic [7:0] io_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {io_port_access, io_rd, io_wr} = 3'h0;
    io_addr = 8'h00;
    io_wdata = 8'h00;
  end

  task automatic rw(input logic w, p, input logic [7:0] a,
                    input logic [15:0] d, input int n,
                    output logic [15:0] q);
    logic hi;
    q = 16'h0000;
    @(posedge sys_clk);
    #1;
    io_port_access = p;
    io_wr = w;
    io_rd = !w;
    for (int i = 0; i < n; i++) begin
      hi = (n == 2) && (w == (i == 0));
      io_addr = a + 8'(hi);
      io_wdata = hi ? d[15:8] : d[7:0];
      @(posedge sys_clk);
      #1;
      if (hi) q[15:8] = io_rdata_q;
      else q[7:0] = io_rdata_q;
    end
    io_rd = 1'h0;
    io_wr = 1'h0;
    // released lines must not keep looking valid
    io_addr = ~io_addr;
    io_wdata = ~io_wdata;
  endtask : rw
endmodule : cpu_io_model

`default_nettype wire

// [sim/tb_timer16_capture_compare_regs.sv]
`default_nettype none

module tb_timer16_capture_compare_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic io_port_access, io_rd, io_wr;
  logic [7:0] io_addr, io_wdata, io_rdata_q;
  logic [15:0] counter1_value = 16'h0000, counter3_value = 16'h0000;
  logic [15:0] compare1a_value = 16'h0000, compare1b_value = 16'hFFFF;
  logic [15:0] capture1_value_q, capture3_value_q, v, w;
  logic timer1_tick = 1'h0, timer3_tick = 1'h0, counter3_written = 1'h0;
  logic counter1_written = 1'h0, forced_match_a_strobe = 1'h0;
  logic capture_input_pin1 = 1'h0, comparator_out = 1'h0;
  logic capture1_from_comparator = 1'h0, capture1_edge_rising = 1'h1;
  logic capture1_is_top = 1'h0, capture_input_pin3 = 1'h0;
  logic capture3_edge_rising = 1'h1, capture3_is_top = 1'h0;
  logic global_irq_enable = 1'h0, t1_capture_vector_ack = 1'h0;
  logic t1_match_a_vector_ack = 1'h0, t1_match_b_vector_ack = 1'h0;
  logic irq_t1_capture_q, irq_t1_match_a_q, irq_t1_match_b_q;
  logic capture3_event_q, match1c_q, match3a_q, match3b_q, match3c_q;
  logic [7:0] ca [4] = '{8'h78, 8'h82, 8'h84, 8'h86};
  int err_count = 0, checks = 0, cyc_n = 0, m3 = 0;

  timer_cc_regs dut_u (.*);
  cpu_io_model cpu_u (.*);

  always #20 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    m3 += int'(match3a_q) + int'(match3b_q);
    m3 += int'(match3c_q) + int'(match1c_q);
    cyc_n++;
    if (cyc_n == 3000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] fl(input logic c, a);
    fl = 8'h00;
    fl[timer_cc_pkg::BIT_T1_CAPTURE] = c;
    fl[timer_cc_pkg::BIT_T1_MATCH_A] = a;
  endfunction : fl

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic rd(input logic p, input logic [7:0] a, input int n,
                    input logic [15:0] e);
    logic [15:0] q;
    cpu_u.rw(1'h0, p, a, 16'h0000, n, q);
    chk(q, e);
  endtask : rd

  task automatic wr(input logic p, input logic [7:0] a, input int n,
                    input logic [15:0] d);
    logic [15:0] q;
    cpu_u.rw(1'h1, p, a, d, n, q);
  endtask : wr

  // one rising trigger on pin or comparator with the counter held
  task automatic trig(input logic cmp, input logic [15:0] c);
    counter1_value = c;
    if (cmp) comparator_out = 1'h1;
    else capture_input_pin1 = 1'h1;
    cyc(4);
    comparator_out = 1'h0;
    capture_input_pin1 = 1'h0;
    cyc(2);
  endtask : trig

  task automatic stop_test;
    $display("errors=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  initial begin
    void'($urandom(30855));
    cyc(3);
    rst_n = 1'h1;
    for (int i = 0; i < 16; i++) rd(0, 8'h78 + 8'(i), 1, 16'h0000);
    for (int i = 0; i < 4; i++) rd(1, 8'(i < 2 ? 38 + i : 52 + i), 1, 0);
    for (int i = 0; i < 8; i++) begin
      v = 16'($urandom);
      wr(0, ca[i % 4], 2, v);
      rd(0, ca[i % 4], 2, v);
    end
    v = 16'($urandom);
    w = 16'($urandom);
    wr(0, 8'h85, 1, w >> 8);
    wr(0, 8'h86, 1, v);
    rd(0, 8'h86, 2, {w[15:8], v[7:0]});
    wr(0, 8'h57, 1, 16'h0038);
    rd(1, 8'h37, 1, 16'h0038);
    wr(1, 8'h86, 1, 16'h00AA);
    rd(0, 8'h86, 1, {8'h00, v[7:0]});
    rd(1, 8'h78, 1, 16'h0000);
    rd(0, 8'h06, 1, 16'h0000);
    global_irq_enable = 1'h1;
    trig(0, v);
    chk(capture1_value_q, v);
    rd(1, 8'h36, 1, fl(1, 0));
    chk(irq_t1_capture_q, 1);
    rd(1, 8'h26, 2, v);
    rd(0, 8'h46, 1, v[7:0]);
    trig(0, w);
    rd(1, 8'h27, 1, v[15:8]);
    chk(capture1_value_q, w);
    wr(1, 8'h36, 1, fl(1, 0));
    rd(1, 8'h36, 1, 16'h0000);
    chk(irq_t1_capture_q, 0);
    capture1_from_comparator = 1'h1;
    trig(0, v);
    chk(capture1_value_q, w);
    trig(1, ~w);
    chk(capture1_value_q, ~w);
    rd(1, 8'h36, 1, fl(1, 0));
    t1_capture_vector_ack = 1'h1;
    cyc(1);
    t1_capture_vector_ack = 1'h0;
    rd(1, 8'h36, 1, 16'h0000);
    capture1_is_top = 1'h1;
    timer1_tick = 1'h1;
    cyc(1);
    timer1_tick = 1'h0;
    rd(1, 8'h36, 1, fl(1, 0));
    capture1_is_top = 1'h0;
    wr(1, 8'h36, 1, fl(1, 0));
    compare1a_value = ~w;
    compare1b_value = ~w;
    wr(0, 8'h78, 2, ~w);
    forced_match_a_strobe = 1'h1;
    cyc(1);
    forced_match_a_strobe = 1'h0;
    rd(1, 8'h36, 1, 16'h0000);
    timer1_tick = 1'h1;
    cyc(1);
    timer1_tick = 1'h0;
    rd(1, 8'h36, 1, fl(0, 1) | 8'(1 << timer_cc_pkg::BIT_T1_MATCH_B));
    chk(irq_t1_match_a_q, 1);
    chk(irq_t1_match_b_q, 1);
    chk(16'(m3), 1);
    global_irq_enable = 1'h0;
    cyc(2);
    chk(irq_t1_match_a_q, 0);
    chk(irq_t1_match_b_q, 0);
    t1_match_a_vector_ack = 1'h1;
    t1_match_b_vector_ack = 1'h1;
    cyc(1);
    t1_match_a_vector_ack = 1'h0;
    t1_match_b_vector_ack = 1'h0;
    rd(1, 8'h36, 1, 16'h0000);
    counter3_value = v;
    capture_input_pin3 = 1'h1;
    cyc(4);
    capture_input_pin3 = 1'h0;
    chk(capture3_value_q, v);
    rd(0, 8'h80, 2, v);
    capture3_edge_rising = 1'h0;
    counter3_value = w;
    capture_input_pin3 = 1'h1;
    cyc(2);
    chk(capture3_value_q, v);
    capture_input_pin3 = 1'h0;
    cyc(2);
    chk(capture3_value_q, w);
    capture3_is_top = 1'h1;
    counter3_value = v;
    capture_input_pin3 = 1'h1;
    cyc(2);
    capture_input_pin3 = 1'h0;
    cyc(2);
    chk(capture3_value_q, w);
    capture3_is_top = 1'h0;
    wr(0, 8'h86, 2, v);
    wr(0, 8'h84, 2, v);
    wr(0, 8'h82, 2, v);
    counter3_written = 1'h1;
    timer3_tick = 1'h1;
    cyc(1);
    counter3_written = 1'h0;
    cyc(1);
    timer3_tick = 1'h0;
    cyc(3);
    chk(16'(m3), 1);
    timer3_tick = 1'h1;
    cyc(1);
    timer3_tick = 1'h0;
    cyc(3);
    chk(16'(m3), 4);
    rst_n = 1'h0;
    cyc(1);
    chk(capture3_value_q, 16'h0000);
    rst_n = 1'h1;
    rd(0, 8'h57, 1, 16'h0000);
    stop_test();
  end
endmodule : tb_timer16_capture_compare_regs

`default_nettype wire
